// ### rtl/pdiag_indicator.sv
// one indicator output: selects its source by code and stretches activity into a visible blink
`timescale 1ns/100ps
module pdiag_indicator #(
  parameter int unsigned BLINK_CYCLES = pdiag_pkg::BLINK_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [pdiag_pkg::IND_W-1:0] source_sel,
  input wire logic link_ok,
  input wire logic activity,
  input wire logic speed_100,
  input wire logic full_duplex,
  output logic indicator_q
);
  import pdiag_pkg::*;
  logic [31:0] stretch_q;
  logic blink_q;
  logic indicator_d;

  // activity starts a stretch window only when none is running; the blink phase flips once per window and is kept
  // across back-to-back windows, so steady traffic gives a visible on/off rhythm
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stretch_q <= 32'h0;
    end else if (activity && stretch_q == 32'h0) begin
      stretch_q <= 32'(BLINK_CYCLES);
    end else if (stretch_q != 32'h0) begin
      stretch_q <= stretch_q - 32'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blink_q <= 1'b0;
    end else if (stretch_q == 32'h1) begin
      blink_q <= ~blink_q;
    end else if (stretch_q == 32'h0 && !activity) begin
      blink_q <= 1'b0; // [R9]
    end
  end

  always_comb begin
    unique case (source_sel)
      SRC_LINK_OK: indicator_d = link_ok;
      SRC_ACTIVITY: indicator_d = stretch_q != 32'h0;
      SRC_MODE_100: indicator_d = link_ok && speed_100; // [R9]
      SRC_MODE_10: indicator_d = link_ok && !speed_100; // [R9]
      SRC_FULL_RESOLVED_FULL_DUPLEX: indicator_d = full_duplex; // [R9]
      SRC_LINK_BLINK: indicator_d = link_ok && !blink_q; // [R9]
      // reserved and undefined codes leave the indicator off
      default: indicator_d = 1'b0; // [R9]
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      indicator_q <= 1'b0;
    end else begin
      indicator_q <= indicator_d;
    end
  end
endmodule

// ### rtl/pdiag_pkg.sv
// package of register map, field layout and reset values for the phy diagnostic and indicator registers
package pdiag_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] OFF_DIAG = 5'h12;
  localparam logic [ADDR_W-1:0] OFF_GAIN = 5'h13;
  localparam logic [ADDR_W-1:0] OFF_IND = 5'h17;
  localparam logic [ADDR_W-1:0] OFF_XOVER = 5'h18;
  localparam int unsigned BIT_NEG_FAIL = 12;
  localparam int unsigned BIT_FULL_RESOLVED_FULL_DUPLEX = 11;
  localparam int unsigned BIT_RATE_100 = 10;
  localparam int unsigned BIT_RX_DET = 9;
  localparam int unsigned BIT_RX_LOCK = 8;
  localparam int unsigned IND_B_LSB = 4;
  localparam int unsigned IND_A_LSB = 0;
  localparam int unsigned IND_W = 4;
  localparam int unsigned GAIN_LSB = 14;
  localparam int unsigned GAIN_W = 2;
  localparam logic [DATA_W-1:0] RST_DIAG = 16'h0000;
  localparam logic [DATA_W-1:0] RST_GAIN = 16'h4000;
  localparam logic [DATA_W-1:0] RST_IND = 16'h0010;
  localparam logic [DATA_W-1:0] RST_XOVER = 16'h00c0;
  localparam logic [IND_W-1:0] SRC_LINK_OK = 4'h0;
  localparam logic [IND_W-1:0] SRC_ACTIVITY = 4'h1;
  localparam logic [IND_W-1:0] SRC_MODE_100 = 4'h5;
  localparam logic [IND_W-1:0] SRC_MODE_10 = 4'h6;
  localparam logic [IND_W-1:0] SRC_FULL_RESOLVED_FULL_DUPLEX = 4'h7;
  localparam logic [IND_W-1:0] SRC_LINK_BLINK = 4'h8;
  // activity stretch / blink period: 50 ms at 20 MHz
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned BLINK_MS = 50;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
endpackage

// ### rtl/pdiag_regs.sv
// phy negotiation diagnostic, transceiver gain, indicator source and crossover control registers
// How it works
// R1: negotiation failure sets bit 12, held until the diagnostic register is read.
// R2: bit 11 reads one for resolved full duplex, zero for half.
// R3: bit 10 reads one for resolved 100 Mb/s, zero for 10 Mb/s.
// R4: bit 9 reads one when receive signal or Manchester data is detected.
// R5: bit 8 reads one while the receive PLL is locked.
// R6: diagnostic bits 15:13 and 7:0 read zero; register resets to zero.
// R7: indicator config bits 7:4 select second indicator source, reset 0x1.
// R8: indicator config bits 3:0 select first indicator source, reset 0x0.
// R9: codes 5,6,7,8 show 100M, 10M, full duplex, link blink; 2-4 reserved.
// R10: transceiver gain register resets to 0x4000; bits 13:0 read zero.
// R11: crossover control register is writable and resets to 0x00c0.
// R12: a failure arriving during a diagnostic read keeps the flag set.
`timescale 1ns/100ps
module pdiag_regs #(
  parameter int unsigned BLINK_CYCLES = pdiag_pkg::BLINK_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [pdiag_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pdiag_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pdiag_pkg::DATA_W-1:0] reg_rdata,
  input wire logic neg_fail_event,
  input wire logic neg_full_duplex,
  input wire logic neg_speed_100,
  input wire logic rx_signal_detect,
  input wire logic rx_pll_locked,
  input wire logic link_ok,
  input wire logic link_activity,
  output logic indicator_a,
  output logic indicator_b,
  output logic [pdiag_pkg::GAIN_W-1:0] tx_gain,
  output logic [pdiag_pkg::DATA_W-1:0] crossover_ctrl
);
  import pdiag_pkg::*;

  logic negotiation_failed_flag_q;
  logic resolved_full_duplex_q;
  logic rate_100_q;
  logic receive_signal_detected_q;
  logic rx_lock_q;
  logic [IND_W-1:0] indicator_a_source_q;
  logic [IND_W-1:0] indicator_b_source_q;
  logic [GAIN_W-1:0] gain_q;
  logic [DATA_W-1:0] xover_q;
  logic [DATA_W-1:0] rdata_d;
  logic diag_rd;
  logic [IND_W-1:0] ind_sel [2];
  logic ind_out [2];

  assign diag_rd = reg_rd && reg_addr == OFF_DIAG;

  // set wins over the read-clear so a failure in the read cycle is kept
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      negotiation_failed_flag_q <= RST_DIAG[BIT_NEG_FAIL]; // [R6]
    end else if (neg_fail_event) begin
      negotiation_failed_flag_q <= 1'b1; // [R1] [R12]
    end else if (diag_rd) begin
      negotiation_failed_flag_q <= 1'b0; // [R1]
    end
  end

  // live status bits registered once so read data come from flip-flops
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      resolved_full_duplex_q <= RST_DIAG[BIT_FULL_RESOLVED_FULL_DUPLEX];
      rate_100_q <= RST_DIAG[BIT_RATE_100];
      receive_signal_detected_q <= RST_DIAG[BIT_RX_DET];
      rx_lock_q <= RST_DIAG[BIT_RX_LOCK];
    end else begin
      resolved_full_duplex_q <= neg_full_duplex; // [R2]
      rate_100_q <= neg_speed_100; // [R3]
      receive_signal_detected_q <= rx_signal_detect; // [R4]
      rx_lock_q <= rx_pll_locked; // [R5]
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      indicator_b_source_q <= RST_IND[IND_B_LSB +: IND_W]; // [R7]
      indicator_a_source_q <= RST_IND[IND_A_LSB +: IND_W]; // [R8]
    end else if (reg_wr && reg_addr == OFF_IND) begin
      indicator_b_source_q <= reg_wdata[IND_B_LSB +: IND_W]; // [R7]
      indicator_a_source_q <= reg_wdata[IND_A_LSB +: IND_W]; // [R8]
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      gain_q <= RST_GAIN[GAIN_LSB +: GAIN_W]; // [R10]
    end else if (reg_wr && reg_addr == OFF_GAIN) begin
      gain_q <= reg_wdata[GAIN_LSB +: GAIN_W]; // [R10]
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      xover_q <= RST_XOVER; // [R11]
    end else if (reg_wr && reg_addr == OFF_XOVER) begin
      xover_q <= reg_wdata; // [R11]
    end
  end

  always_comb begin
    rdata_d = '0;
    unique case (reg_addr)
      OFF_DIAG: begin
        // bits 15:13 and 7:0 stay zero
        rdata_d[BIT_NEG_FAIL] = negotiation_failed_flag_q; // [R6]
        rdata_d[BIT_FULL_RESOLVED_FULL_DUPLEX] = resolved_full_duplex_q;
        rdata_d[BIT_RATE_100] = rate_100_q;
        rdata_d[BIT_RX_DET] = receive_signal_detected_q;
        rdata_d[BIT_RX_LOCK] = rx_lock_q;
      end
      OFF_GAIN: rdata_d[GAIN_LSB +: GAIN_W] = gain_q; // [R10]
      OFF_IND: begin
        rdata_d[IND_B_LSB +: IND_W] = indicator_b_source_q;
        rdata_d[IND_A_LSB +: IND_W] = indicator_a_source_q;
      end
      OFF_XOVER: rdata_d = xover_q;
      default: rdata_d = '0;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_gain <= RST_GAIN[GAIN_LSB +: GAIN_W];
      crossover_ctrl <= RST_XOVER;
    end else begin
      tx_gain <= gain_q;
      crossover_ctrl <= xover_q;
    end
  end

  // index 0 drives the first indicator, index 1 the second
  assign ind_sel[0] = indicator_a_source_q; // [R8]
  assign ind_sel[1] = indicator_b_source_q; // [R7]

  for (genvar i = 0; i < 2; i++) begin : g_ind
    pdiag_indicator #(
      .BLINK_CYCLES(BLINK_CYCLES)
    ) u_ind (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .source_sel(ind_sel[i]),
      .link_ok(link_ok),
      .activity(link_activity),
      .speed_100(rate_100_q),
      .full_duplex(resolved_full_duplex_q),
      .indicator_q(ind_out[i])
    );
  end

  assign indicator_a = ind_out[0];
  assign indicator_b = ind_out[1];
endmodule

// ### test/pdiag_regs_properties.sv
// concurrent checks on the register port and control outputs of the register block
`timescale 1ns/100ps
module pdiag_regs_properties (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [pdiag_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pdiag_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pdiag_pkg::DATA_W-1:0] reg_rdata,
  input wire logic neg_fail_event,
  input wire logic neg_full_duplex,
  input wire logic neg_speed_100,
  input wire logic rx_signal_detect,
  input wire logic rx_pll_locked,
  input wire logic [pdiag_pkg::GAIN_W-1:0] tx_gain,
  input wire logic [pdiag_pkg::DATA_W-1:0] crossover_ctrl
);
  import pdiag_pkg::*;
  wire rd_diag = reg_rd && reg_addr == OFF_DIAG;
  wire [1:0] res_st = {neg_full_duplex, neg_speed_100};
  wire [1:0] rx_st = {rx_signal_detect, rx_pll_locked};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_diag_reserved: assert property (rd_diag |=> reg_rdata[15:13] == 3'h0 && reg_rdata[7:0] == 8'h00)
    else $error("diag reserved bits not zero");
  a_diag_resolved: assert property (rd_diag && $past(arst_n) && $stable(res_st) |=> reg_rdata[11:10] == $past(res_st))
    else $error("diag duplex or rate bit wrong");
  a_diag_receive: assert property (rd_diag && $past(arst_n) && $stable(rx_st) |=> reg_rdata[9:8] == $past(rx_st))
    else $error("diag receive bits wrong");
  a_fail_sticky: assert property (neg_fail_event ##1 !rd_diag ##1 rd_diag |=> reg_rdata[12])
    else $error("failure flag lost");
  a_fail_clear: assert property (rd_diag && !neg_fail_event ##1 !neg_fail_event ##1 rd_diag |=> !reg_rdata[12])
    else $error("failure flag not cleared by read");
  a_gain_reserved: assert property (reg_rd && reg_addr == OFF_GAIN |=> reg_rdata[13:0] == 14'h0000)
    else $error("gain reserved bits not zero");
  a_ind_reserved: assert property (reg_rd && reg_addr == OFF_IND |=> reg_rdata[15:8] == 8'h00)
    else $error("indicator reserved bits not zero");
  a_gain_follow: assert property (reg_wr && reg_addr == OFF_GAIN |=> ##1 tx_gain == $past(reg_wdata[15:14], 2))
    else $error("gain output does not follow write");
  a_xover_follow: assert property (reg_wr && reg_addr == OFF_XOVER |=> ##1 crossover_ctrl == $past(reg_wdata, 2))
    else $error("crossover output does not follow write");
endmodule

// ### test/phy_diag_indicator_regs_tb_top.sv
// self-checking bench for the diagnostic and indicator register block
`timescale 1ns/100ps
module phy_diag_indicator_regs_tb_top;
  import pdiag_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, ev = 1'b0;
  logic resolved_full_duplex = 1'b0, spd = 1'b0, det = 1'b0, lock = 1'b0, lnk = 1'b0, act = 1'b0;
  logic [DATA_W-1:0] reg_rdata, xover;
  logic ind_a, ind_b;
  logic [GAIN_W-1:0] gain;
  int bad_count = 0;
  int checks_done = 0;
  int lows = 0;
  pdiag_regs #(.BLINK_CYCLES(4)) dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .neg_fail_event(ev),
    .neg_full_duplex(resolved_full_duplex), .neg_speed_100(spd), .rx_signal_detect(det), .rx_pll_locked(lock), .link_ok(lnk),
    .link_activity(act), .indicator_a(ind_a), .indicator_b(ind_b), .tx_gain(gain), .crossover_ctrl(xover));
  initial forever #25 clk_sys = ~clk_sys;
  task automatic conclude();
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read with an optional failure event raised in the same cycle as the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic f);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    ev <= f;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    ev <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // link up, 100 Mb/s, full duplex, no activity
  function automatic logic ind_exp(input int c);
    return c == 0 || c == 5 || c == 7 || c == 8;
  endfunction
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    chk(16'(gain), 16'h0001);
    chk(xover, 16'h00c0);
    arst_n <= 1'b1;
    rd(OFF_DIAG, 16'h0000, 1'b0);
    rd(OFF_GAIN, 16'h4000, 1'b0);
    rd(OFF_IND, 16'h0010, 1'b0);
    rd(OFF_XOVER, 16'h00c0, 1'b0);
    wr(OFF_GAIN, 16'hffff);
    wr(OFF_XOVER, 16'h1234);
    wr(OFF_DIAG, 16'hffff);
    wr(5'h00, 16'hffff);
    rd(OFF_GAIN, 16'hc000, 1'b0);
    rd(OFF_XOVER, 16'h1234, 1'b0);
    rd(5'h00, 16'h0000, 1'b0);
    chk(16'(gain), 16'h0003);
    chk(xover, 16'h1234);
    @(posedge clk_sys);
    resolved_full_duplex <= 1'b1;
    det <= 1'b1;
    rd(OFF_DIAG, 16'h0a00, 1'b0);
    @(posedge clk_sys);
    resolved_full_duplex <= 1'b0;
    det <= 1'b0;
    spd <= 1'b1;
    lock <= 1'b1;
    rd(OFF_DIAG, 16'h0500, 1'b0);
    @(posedge clk_sys);
    det <= 1'b1;
    lock <= 1'b0;
    rd(OFF_GAIN, 16'hc000, 1'b1);
    rd(OFF_DIAG, 16'h1600, 1'b1);
    rd(OFF_DIAG, 16'h1600, 1'b0);
    rd(OFF_DIAG, 16'h0600, 1'b0);
    @(posedge clk_sys);
    lnk <= 1'b1;
    resolved_full_duplex <= 1'b1;
    for (int c = 0; c < 9; c++) begin
      wr(OFF_IND, {8'h00, c[3:0], c[3:0]});
      repeat (2) @(posedge clk_sys);
      #1 chk(16'({ind_b, ind_a}), 16'({2{ind_exp(c)}}));
    end
    @(posedge clk_sys);
    spd <= 1'b0;
    wr(OFF_IND, 16'h0056);
    repeat (2) @(posedge clk_sys);
    #1 chk(16'({ind_b, ind_a}), 16'h0001);
    wr(OFF_IND, 16'h0010);
    @(posedge clk_sys);
    act <= 1'b1;
    @(posedge clk_sys);
    act <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk(16'({ind_b, ind_a}), 16'h0003);
    repeat (10) @(posedge clk_sys);
    #1 chk(16'({ind_b, ind_a}), 16'h0001);
    // steady activity on the blink code must both blank and show the indicator
    wr(OFF_IND, 16'h0080);
    @(posedge clk_sys);
    act <= 1'b1;
    repeat (12) begin
      @(posedge clk_sys);
      #1 lows += 32'(!ind_b);
    end
    @(posedge clk_sys);
    act <= 1'b0;
    chk(16'(lows > 0 && lows < 12), 16'h0001);
    repeat (8) @(posedge clk_sys);
    #1 chk(16'({ind_b, ind_a}), 16'h0003);
    conclude();
  end
endmodule
bind pdiag_regs pdiag_regs_properties chk_i (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .neg_fail_event(neg_fail_event),
  .neg_full_duplex(neg_full_duplex), .neg_speed_100(neg_speed_100), .rx_signal_detect(rx_signal_detect),
  .rx_pll_locked(rx_pll_locked), .tx_gain(tx_gain), .crossover_ctrl(crossover_ctrl));
